/* design/ahc_consts.vh */
// Constants for the audio processor host control port.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef AHC_CONSTS_VH
`define AHC_CONSTS_VH

// Clock and timing figures
`define AHC_CLK_KHZ 50000
`define AHC_ALIVE_PERIOD_MS 170
`define AHC_ALIVE_HALF_CYC ((`AHC_ALIVE_PERIOD_MS * `AHC_CLK_KHZ) / 2)
`define AHC_ACT_TIMEOUT_MS 1
`define AHC_ACT_TIMEOUT_CYC (`AHC_ACT_TIMEOUT_MS * `AHC_CLK_KHZ)
`define AHC_STRAP_WAIT 2'h2

// Link framing
`define AHC_BYTE_BITS 8
`define AHC_LAST_BIT 3'h7
`define AHC_ADDR_UPPER 6'h1A
`define AHC_RW_READ 1'h1

// Command codes for the first entry and for entries 1E to 28 of the command set
`define AHC_CMD_SET_TASK 8'h01
`define AHC_CMD_LAST_SETUP 8'h1E
`define AHC_CMD_FW_VERSION 8'h1F
`define AHC_CMD_FW_REVISION 8'h20
`define AHC_CMD_SW_RESET 8'h21
`define AHC_CMD_NOSIG_READ 8'h22
`define AHC_CMD_NOSIG_CLEAR 8'h23
`define AHC_CMD_DET_ENABLE 8'h24
`define AHC_CMD_DET_DISABLE 8'h25
`define AHC_CMD_BOOT_MUTE 8'h26
`define AHC_CMD_BOOT_UNMUTE 8'h27
`define AHC_CMD_NOP 8'h28

// Reset and saturation values
`define AHC_NOSIG_MAX 8'hFF
`define AHC_BYTE_ZERO 8'h00

`endif

/* design/ahc_host_port.v */
// Host control port of an audio processor: serial slave, command decode,
// boot strap handling and alive toggle output.
// Assumes pins arrive asynchronously and an external pull-up on the data line.
//
// Operation
// - Every control transfer moves one 8-bit byte per packet in either direction.
// - The low bit of the seven-bit slave address comes from the address pin.
// - The address pin low selects low bit 0 and high selects 1.
// - The bit after the address is 0 for write and 1 for read.
// - The slave works with masters at 100 kbps and 400 kbps.
// - The data line is only pulled low or released, never driven high.
// - With the hold strap high at reset the block idles until a start command.
// - With the hold strap low at reset the block runs at once with volume muted.
// - While processing, the alive output toggles with a period near 170 ms.
// - The alive toggling stops when the audio interface clock stops.
// - Forty host commands are accepted, readbacks, resets and flags among them.
`timescale 1ns/1ns
`include "ahc_consts.vh"

module ahc_host_port #(
    parameter ALIVE_HALF_CYC = `AHC_ALIVE_HALF_CYC,
    parameter ACT_TIMEOUT_CYC = `AHC_ACT_TIMEOUT_CYC,
    parameter [7:0] FW_VERSION = 8'h01, // Arbitrary value
    parameter [7:0] FW_REVISION = 8'h00 // Arbitrary value
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Serial control port pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Straps
    input wire slave_addr_low_bit_pin,
    input wire boot_hold_strap,
    // Audio interface activity, the frame clock pin
    input wire audio_lr_clk,
    // Alive toggle output, open drain
    output wire alive_toggle_output_out,
    output wire alive_toggle_output_oe,
    // Command stream to the processing core
    output reg cmd_valid_ff,
    output reg [7:0] cmd_code_ff,
    output reg cmd_param_valid_ff,
    output reg [7:0] cmd_param_ff,
    // Status to the processing core
    output reg running_ff,
    output reg master_mute_ff,
    output reg boot_mute_ff,
    output reg det_enable_ff,
    output wire no_signal_detect
);
    reg [1:0] addr_sync_ff;
    reg [1:0] strap_sync_ff;
    reg [1:0] lr_sync_ff;
    reg lr_d_ff;
    reg [1:0] strap_wait_ff;
    reg strap_taken_ff;
    reg strap_ff;
    reg [31:0] act_cnt_ff;
    reg active_ff;
    reg [31:0] alive_cnt_ff;
    reg alive_ff;
    reg [7:0] nosig_cnt_ff;
    reg [7:0] last_cmd_ff;
    reg [7:0] tx_data_ff;

    wire rx_valid;
    wire [7:0] rx_data;
    wire rx_first;
    wire tx_req;
    wire lr_edge = lr_sync_ff[1] ^ lr_d_ff;

    function is_known;
        input [7:0] code;
        begin
            is_known = (code >= `AHC_CMD_SET_TASK) && (code <= `AHC_CMD_NOP);
        end
    endfunction

    ahc_i2c_slave u_slave (
        .clock(clock),
        .rstn(rstn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_low(addr_sync_ff[1]),
        .rx_valid_ff(rx_valid),
        .rx_data_ff(rx_data),
        .rx_first_ff(rx_first),
        .tx_data(tx_data_ff),
        .tx_req_ff(tx_req)
    );

    wire cmd_in = rx_valid & rx_first & is_known(rx_data);
    wire nosig_clear = cmd_in & (rx_data == `AHC_CMD_NOSIG_CLEAR);
    wire act_timeout = (act_cnt_ff == ACT_TIMEOUT_CYC - 1);

    assign alive_toggle_output_out = 1'b0;
    assign alive_toggle_output_oe = ~alive_ff;
    assign no_signal_detect = det_enable_ff & ~active_ff;

    // Pin synchronisers and strap capture after reset release
    always @(posedge clock) begin
        if (!rstn) begin
            addr_sync_ff <= 2'h0;
            strap_sync_ff <= 2'h0;
            lr_sync_ff <= 2'h0;
            lr_d_ff <= 1'b0;
            strap_wait_ff <= 2'h0;
            strap_taken_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else begin
            addr_sync_ff <= {addr_sync_ff[0], slave_addr_low_bit_pin};
            strap_sync_ff <= {strap_sync_ff[0], boot_hold_strap};
            lr_sync_ff <= {lr_sync_ff[0], audio_lr_clk};
            lr_d_ff <= lr_sync_ff[1];
            if (!strap_taken_ff) begin
                strap_wait_ff <= strap_wait_ff + 2'h1;
                if (strap_wait_ff == `AHC_STRAP_WAIT) begin
                    strap_taken_ff <= 1'b1;
                    strap_ff <= strap_sync_ff[1];
                end
            end
        end
    end

    // Audio activity: frame clock edges seen within the timeout
    always @(posedge clock) begin
        if (!rstn) begin
            act_cnt_ff <= 32'h0;
            active_ff <= 1'b0;
            nosig_cnt_ff <= `AHC_BYTE_ZERO;
        end else begin
            if (lr_edge) begin
                act_cnt_ff <= 32'h0;
                active_ff <= 1'b1;
            end else if (act_timeout) begin
                active_ff <= 1'b0;
            end else begin
                act_cnt_ff <= act_cnt_ff + 32'h1;
            end
            // Counter increment wins over a clear in the same cycle
            if (active_ff && act_timeout && !lr_edge) begin
                if (nosig_cnt_ff != `AHC_NOSIG_MAX) begin
                    nosig_cnt_ff <= nosig_cnt_ff + 8'h01;
                end
            end else if (nosig_clear) begin
                nosig_cnt_ff <= `AHC_BYTE_ZERO;
            end
        end
    end

    // Alive toggle, paced by the system clock but gated by audio activity
    always @(posedge clock) begin
        if (!rstn) begin
            alive_cnt_ff <= 32'h0;
            alive_ff <= 1'b1;
        end else if (running_ff && active_ff) begin
            if (alive_cnt_ff == ALIVE_HALF_CYC - 1) begin
                alive_cnt_ff <= 32'h0;
                alive_ff <= ~alive_ff;
            end else begin
                alive_cnt_ff <= alive_cnt_ff + 32'h1;
            end
        end
    end

    // Command decode and run state
    always @(posedge clock) begin
        if (!rstn) begin
            running_ff <= 1'b0;
            master_mute_ff <= 1'b1;
            boot_mute_ff <= 1'b1;
            det_enable_ff <= 1'b0;
            last_cmd_ff <= `AHC_CMD_NOP;
            cmd_valid_ff <= 1'b0;
            cmd_code_ff <= `AHC_BYTE_ZERO;
            cmd_param_valid_ff <= 1'b0;
            cmd_param_ff <= `AHC_BYTE_ZERO;
        end else begin
            cmd_valid_ff <= cmd_in;
            cmd_param_valid_ff <= rx_valid & ~rx_first;
            if (rx_valid && !rx_first) begin
                cmd_param_ff <= rx_data;
            end
            if (strap_wait_ff == `AHC_STRAP_WAIT && !strap_taken_ff) begin
                running_ff <= ~strap_sync_ff[1];
            end
            if (cmd_in) begin
                cmd_code_ff <= rx_data;
                last_cmd_ff <= rx_data;
                case (rx_data)
                    `AHC_CMD_SET_TASK: begin
                        running_ff <= 1'b1;
                    end
                    `AHC_CMD_SW_RESET: begin
                        running_ff <= ~strap_ff;
                        master_mute_ff <= boot_mute_ff;
                        det_enable_ff <= 1'b0;
                    end
                    `AHC_CMD_DET_ENABLE: begin
                        det_enable_ff <= 1'b1;
                    end
                    `AHC_CMD_DET_DISABLE: begin
                        det_enable_ff <= 1'b0;
                    end
                    `AHC_CMD_BOOT_MUTE: begin
                        boot_mute_ff <= 1'b1;
                    end
                    `AHC_CMD_BOOT_UNMUTE: begin
                        boot_mute_ff <= 1'b0;
                    end
                    default: begin
                        last_cmd_ff <= rx_data;
                    end
                endcase
            end
        end
    end

    // Read answer byte follows the last command
    always @(posedge clock) begin
        if (!rstn) begin
            tx_data_ff <= `AHC_BYTE_ZERO;
        end else begin
            case (last_cmd_ff)
                `AHC_CMD_FW_VERSION: tx_data_ff <= FW_VERSION;
                `AHC_CMD_FW_REVISION: tx_data_ff <= FW_REVISION;
                `AHC_CMD_NOSIG_READ: tx_data_ff <= nosig_cnt_ff;
                default: tx_data_ff <= `AHC_BYTE_ZERO;
            endcase
        end
    end
endmodule // ahc_host_port

/* design/ahc_i2c_slave.v */
// Byte-level two-wire serial slave for the host control port.
// Assumes scl_in and sda_in come from pins; both are synchronised here.
`timescale 1ns/1ns
`include "ahc_consts.vh"

module ahc_i2c_slave (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Link pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Address low bit, already synchronised
    input wire addr_low,
    // Received bytes
    output reg rx_valid_ff,
    output reg [7:0] rx_data_ff,
    output reg rx_first_ff,
    // Bytes to send
    input wire [7:0] tx_data,
    output reg tx_req_ff
);
    localparam S_IDLE = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_ACKA = 3'h2;
    localparam S_WR = 3'h3;
    localparam S_ACKW = 3'h4;
    localparam S_RD = 3'h5;
    localparam S_ACKR = 3'h6;

    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg scl_d_ff;
    reg sda_d_ff;
    reg [2:0] state_ff;
    reg [2:0] bit_cnt_ff;
    reg got_ff;
    reg [7:0] sh_ff;
    reg [7:0] tx_sh_ff;
    reg rw_ff;
    reg nack_ff;
    reg oe_ff;
    reg first_ff;

    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_seen = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire addr_match = (sh_ff[7:1] == {`AHC_ADDR_UPPER, addr_low});

    assign sda_out = 1'b0;
    assign sda_oe = oe_ff;

    always @(posedge clock) begin
        if (!rstn) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            state_ff <= S_IDLE;
            bit_cnt_ff <= 3'h0;
            got_ff <= 1'b0;
            sh_ff <= `AHC_BYTE_ZERO;
            tx_sh_ff <= `AHC_BYTE_ZERO;
            rw_ff <= 1'b0;
            nack_ff <= 1'b0;
            oe_ff <= 1'b0;
            first_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_data_ff <= `AHC_BYTE_ZERO;
            rx_first_ff <= 1'b0;
            tx_req_ff <= 1'b0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            rx_valid_ff <= 1'b0;
            tx_req_ff <= 1'b0;
            if (start_seen) begin
                state_ff <= S_ADDR;
                bit_cnt_ff <= 3'h0;
                got_ff <= 1'b0;
                oe_ff <= 1'b0;
            end else if (stop_seen) begin
                state_ff <= S_IDLE;
                oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    S_ADDR, S_WR: begin
                        // Eight bits make one unit, MSB first
                        if (scl_rise) begin
                            sh_ff <= {sh_ff[6:0], sda_s};
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                            if (bit_cnt_ff == `AHC_LAST_BIT) begin
                                got_ff <= 1'b1;
                            end
                        end else if (scl_fall && got_ff) begin
                            got_ff <= 1'b0;
                            if (state_ff == S_WR) begin
                                oe_ff <= 1'b1;
                                state_ff <= S_ACKW;
                                rx_valid_ff <= 1'b1;
                                rx_data_ff <= sh_ff;
                                rx_first_ff <= first_ff;
                                first_ff <= 1'b0;
                            end else if (addr_match) begin
                                oe_ff <= 1'b1;
                                state_ff <= S_ACKA;
                                rw_ff <= (sh_ff[0] == `AHC_RW_READ);
                            end else begin
                                state_ff <= S_IDLE;
                            end
                        end
                    end
                    S_ACKA: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= 3'h0;
                            if (rw_ff) begin
                                state_ff <= S_RD;
                                tx_sh_ff <= tx_data;
                                oe_ff <= ~tx_data[7];
                                tx_req_ff <= 1'b1;
                            end else begin
                                state_ff <= S_WR;
                                oe_ff <= 1'b0;
                                first_ff <= 1'b1;
                            end
                        end
                    end
                    S_ACKW: begin
                        if (scl_fall) begin
                            oe_ff <= 1'b0;
                            state_ff <= S_WR;
                        end
                    end
                    S_RD: begin
                        if (scl_fall) begin
                            if (bit_cnt_ff == `AHC_LAST_BIT) begin
                                oe_ff <= 1'b0;
                                state_ff <= S_ACKR;
                            end else begin
                                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                                oe_ff <= ~tx_sh_ff[6];
                                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                            end
                        end
                    end
                    S_ACKR: begin
                        if (scl_rise) begin
                            nack_ff <= sda_s;
                        end else if (scl_fall) begin
                            bit_cnt_ff <= 3'h0;
                            if (nack_ff) begin
                                state_ff <= S_IDLE;
                            end else begin
                                state_ff <= S_RD;
                                tx_sh_ff <= tx_data;
                                oe_ff <= ~tx_data[7];
                                tx_req_ff <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // ahc_i2c_slave

/* dv/ahc_host_model.sv */
// Two-wire bus master standing in for the host microcontroller.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module ahc_host_model (
    // Clock
    input logic clock,
    // Bus lines
    input logic sda_in,
    output logic scl_ff,
    output logic sda_low_ff
);
    int half_cyc = 63;
    initial begin
        scl_ff = 1'b1;
        sda_low_ff = 1'b0;
    end
    task automatic wait_c(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Start or repeated start; data held 6 cycles past each clock fall
    task automatic start_c();
        sda_low_ff <= 1'b0;
        wait_c(half_cyc);
        scl_ff <= 1'b1;
        wait_c(half_cyc);
        sda_low_ff <= 1'b1;
        wait_c(half_cyc);
        scl_ff <= 1'b0;
        wait_c(6);
    endtask
    task automatic bit_out(input logic b);
        sda_low_ff <= !b;
        wait_c(half_cyc - 6);
        scl_ff <= 1'b1;
        wait_c(half_cyc);
        scl_ff <= 1'b0;
        wait_c(6);
    endtask
    task automatic bit_in(output logic b);
        sda_low_ff <= 1'b0;
        wait_c(half_cyc - 6);
        scl_ff <= 1'b1;
        wait_c(half_cyc / 2);
        b = sda_in;
        wait_c(half_cyc - half_cyc / 2);
        scl_ff <= 1'b0;
        wait_c(6);
    endtask
    // Whole bytes, most significant bit first
    task automatic send_b(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = !b;
    endtask
    task automatic recv_b(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(!ack);
    endtask
    // Stop, then an idle gap before the next command
    task automatic stop_c();
        sda_low_ff <= 1'b1;
        wait_c(half_cyc);
        scl_ff <= 1'b1;
        wait_c(half_cyc);
        sda_low_ff <= 1'b0;
        wait_c(4 * half_cyc);
    endtask
endmodule // ahc_host_model

/* dv/ahc_host_port_chk.sv */
// Port-level checker for the host control port.
// Assumes one clock domain and reset counts short enough for simulation.
`timescale 1ns/1ns
module ahc_host_port_chk #(
    parameter int ALIVE_HALF_CYC = 50,
    parameter int ACT_TIMEOUT_CYC = 20
) (
    // Clock and reset
    input logic clock,
    input logic rstn,
    // Link and straps
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe,
    input logic slave_addr_low_bit_pin,
    input logic boot_hold_strap,
    input logic audio_lr_clk,
    input logic alive_toggle_output_out,
    input logic alive_toggle_output_oe,
    // Core side
    input logic cmd_valid_ff,
    input logic [7:0] cmd_code_ff,
    input logic cmd_param_valid_ff,
    input logic [7:0] cmd_param_ff,
    input logic running_ff,
    input logic master_mute_ff,
    input logic boot_mute_ff,
    input logic det_enable_ff,
    input logic no_signal_detect
);
    int alive_cnt_ff;
    int idle_cnt_ff;
    always @(posedge clock) begin
        if (!rstn) begin
            alive_cnt_ff <= 0;
            idle_cnt_ff <= 0;
        end else begin
            alive_cnt_ff <= $changed(alive_toggle_output_oe) ? 0 : alive_cnt_ff + 1;
            idle_cnt_ff <= $changed(audio_lr_clk) ? 0 : idle_cnt_ff + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sda_drive_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    alive_drive_a: assert property (alive_toggle_output_out == 1'b0)
        else $error("alive pin driven high");
    sda_timing_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
    cmd_pulse_a: assert property (cmd_valid_ff |=> !cmd_valid_ff)
        else $error("command pulse too long");
    param_pulse_a: assert property (cmd_param_valid_ff |=> !cmd_param_valid_ff)
        else $error("parameter pulse too long");
    det_gate_a: assert property (!det_enable_ff |-> !no_signal_detect)
        else $error("no-signal flag while disabled");
    nosig_flag_a: assert property (det_enable_ff && idle_cnt_ff > ACT_TIMEOUT_CYC + 4
        |-> no_signal_detect)
        else $error("no-signal flag missing");
    hold_idle_a: assert property (!running_ff |=> $stable(alive_toggle_output_oe))
        else $error("alive toggled while idle");
    alive_freeze_a: assert property (idle_cnt_ff > ACT_TIMEOUT_CYC + 4
        |=> $stable(alive_toggle_output_oe))
        else $error("alive toggled without audio");
    alive_period_a: assert property ($changed(alive_toggle_output_oe)
        |-> alive_cnt_ff >= ALIVE_HALF_CYC - 1)
        else $error("alive half period too short");
    cover property (cmd_valid_ff);
    cover property (cmd_param_valid_ff);
    cover property ($changed(alive_toggle_output_oe));
    cover property ($rose(no_signal_detect));
endmodule // ahc_host_port_chk
bind ahc_host_port ahc_host_port_chk #(.ALIVE_HALF_CYC(ALIVE_HALF_CYC),
    .ACT_TIMEOUT_CYC(ACT_TIMEOUT_CYC)) u_chk (.clock(clock), .rstn(rstn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .slave_addr_low_bit_pin(slave_addr_low_bit_pin), .boot_hold_strap(boot_hold_strap),
    .audio_lr_clk(audio_lr_clk), .alive_toggle_output_out(alive_toggle_output_out),
    .alive_toggle_output_oe(alive_toggle_output_oe), .cmd_valid_ff(cmd_valid_ff),
    .cmd_code_ff(cmd_code_ff), .cmd_param_valid_ff(cmd_param_valid_ff),
    .cmd_param_ff(cmd_param_ff), .running_ff(running_ff), .master_mute_ff(master_mute_ff),
    .boot_mute_ff(boot_mute_ff), .det_enable_ff(det_enable_ff),
    .no_signal_detect(no_signal_detect));

/* dv/tb_top.sv */
// Self-checking bench for the host control port with a bus master model.
// Assumes short alive and activity counts set at the instance.
`timescale 1ns/1ns
`include "ahc_consts.vh"
module tb_top;
    logic clock, rstn, scl, host_low, addr_pin, strap, lr_clk, lr_run, alive_q, sda_out, sda_oe;
    logic alive_out, alive_oe, cmd_valid, par_valid, running, mute, bmute, det_en, nosig, ok;
    logic [7:0] cmd_code, par_data, last_par, d;
    logic [1:0] lr_div;
    int failures = 0, cmp_count = 0, n_cmd = 0, n_par = 0, n_alive = 0, n0;
    wire sda_wire = !(sda_oe | host_low);
    ahc_host_port #(.ALIVE_HALF_CYC(50), .ACT_TIMEOUT_CYC(20), .FW_VERSION(8'h5A),
        .FW_REVISION(8'h3C)) u_dut (.clock(clock), .rstn(rstn), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .slave_addr_low_bit_pin(addr_pin), .boot_hold_strap(strap), .audio_lr_clk(lr_clk),
        .alive_toggle_output_out(alive_out), .alive_toggle_output_oe(alive_oe),
        .cmd_valid_ff(cmd_valid), .cmd_code_ff(cmd_code), .cmd_param_valid_ff(par_valid),
        .cmd_param_ff(par_data), .running_ff(running), .master_mute_ff(mute),
        .boot_mute_ff(bmute), .det_enable_ff(det_en), .no_signal_detect(nosig));
    ahc_host_model u_host (.clock(clock), .sda_in(sda_wire), .scl_ff(scl), .sda_low_ff(host_low));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (par_valid === 1'b1) begin
            n_par <= n_par + 1;
            last_par <= par_data;
        end
        if (alive_oe !== alive_q) n_alive <= n_alive + 1;
        alive_q <= alive_oe;
        lr_div <= lr_div + 2'h1;
        if (lr_run && lr_div == 2'h3) lr_clk <= ~lr_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
        @(posedge clock);
    endtask
    function automatic logic [7:0] sa(input logic rw);
        return {`AHC_ADDR_UPPER, addr_pin, rw};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] c, output logic k);
        logic k1, k2;
        k2 = 1'b0;
        u_host.start_c();
        u_host.send_b(a, k1);
        if (k1) u_host.send_b(c, k2);
        u_host.stop_c();
        k = k1 & k2;
    endtask
    task automatic rd(input logic [7:0] c, output logic [7:0] v);
        logic k;
        u_host.start_c();
        u_host.send_b(sa(1'b0), k);
        u_host.send_b(c, k);
        u_host.start_c();
        u_host.send_b(sa(1'b1), k);
        u_host.recv_b(v, 1'b0);
        u_host.stop_c();
    endtask
    task automatic do_reset(input logic s);
        rstn <= 1'b0;
        strap <= s;
        // The check below spends the twelfth reset edge
        repeat (11) @(posedge clock);
        chk({mute, running, sda_oe, alive_oe, det_en, bmute}, 8'h21);
        rstn <= 1'b1;
        repeat (6) @(posedge clock);
        chk(running, !s);
    endtask
    task automatic t_hold();
        do_reset(1'b1);
        lr_run <= 1'b1;
        n0 = n_alive;
        repeat (200) @(posedge clock);
        chk(8'(n_alive - n0), 8'h00);
        wr({`AHC_ADDR_UPPER, ~addr_pin, 1'b0}, `AHC_CMD_SET_TASK, ok);
        chk({ok, running}, 8'h00);
    endtask
    task automatic t_start();
        logic k1, k2, k3;
        n0 = n_cmd;
        u_host.start_c();
        u_host.send_b(sa(1'b0), k1);
        u_host.send_b(`AHC_CMD_SET_TASK, k2);
        u_host.send_b(8'hA5, k3);
        u_host.stop_c();
        chk({k1, k2, k3, 8'(n_cmd - n0) == 8'h01, n_par == 1}, 8'h1F);
        chk(cmd_code, `AHC_CMD_SET_TASK);
        chk(last_par, 8'hA5);
        chk(running, 8'h01);
    endtask
    task automatic t_alive();
        n0 = n_alive;
        repeat (200) @(posedge clock);
        chk(n_alive - n0 >= 3 && n_alive - n0 <= 4, 8'h01);
        lr_run <= 1'b0;
        repeat (60) @(posedge clock);
        n0 = n_alive;
        repeat (200) @(posedge clock);
        chk(8'(n_alive - n0), 8'h00);
        lr_run <= 1'b1;
        rd(`AHC_CMD_FW_VERSION, d);
        chk(d, 8'h5A);
        rd(`AHC_CMD_FW_REVISION, d);
        chk(d, 8'h3C);
    endtask
    task automatic t_addr_pin();
        addr_pin <= 1'b1;
        repeat (4) @(posedge clock);
        wr(sa(1'b0), `AHC_CMD_NOP, ok);
        chk(ok, 8'h01);
        wr({`AHC_ADDR_UPPER, 1'b0, 1'b0}, `AHC_CMD_NOP, ok);
        chk(ok, 8'h00);
        addr_pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic t_codes();
        logic [7:0] codes [6] = '{8'h1E, 8'h26, 8'h27, 8'h28, 8'h00, 8'h29};
        for (int i = 0; i < 6; i++) begin
            n0 = n_cmd;
            wr(sa(1'b0), codes[i], ok);
            chk(8'(n_cmd - n0), i < 4);
            if (i < 4) chk(cmd_code, codes[i]);
        end
        wr(sa(1'b0), `AHC_CMD_SW_RESET, ok);
        chk({bmute, running, mute}, 8'h00);
        wr(sa(1'b0), `AHC_CMD_SET_TASK, ok);
        chk(running, 8'h01);
    endtask
    task automatic t_detect();
        wr(sa(1'b0), `AHC_CMD_DET_ENABLE, ok);
        chk({det_en, nosig}, 8'h02);
        lr_run <= 1'b0;
        repeat (60) @(posedge clock);
        chk(nosig, 8'h01);
        rd(`AHC_CMD_NOSIG_READ, d);
        chk(d, 8'h02);
        lr_run <= 1'b1;
        repeat (20) @(posedge clock);
        wr(sa(1'b0), `AHC_CMD_NOSIG_CLEAR, ok);
        rd(`AHC_CMD_NOSIG_READ, d);
        chk(d, 8'h00);
        wr(sa(1'b0), `AHC_CMD_DET_DISABLE, ok);
        chk({det_en, nosig}, 8'h00);
    endtask
    task automatic t_boot_run();
        u_host.half_cyc = 250;
        do_reset(1'b0);
        chk(mute, 8'h01);
        wr(sa(1'b0), `AHC_CMD_NOP, ok);
        chk(ok, 8'h01);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {rstn, addr_pin, strap, lr_clk, lr_run, alive_q, lr_div} = 8'h00;
        t_hold();
        t_start();
        t_alive();
        t_addr_pin();
        t_codes();
        t_detect();
        t_boot_run();
        test_done();
    end
    initial begin
        repeat (95000) @(posedge clock);
        failures++;
        test_done();
    end
endmodule // tb_top
